//--- rtl/chan_seq_regs.svh
/*
 * Constants for the channel enable sequencing block: mask bit positions,
 * engine counts, sequence store layout and reset values.
 * Assumes inclusion by the package, the design modules and the testbench files.
 */
// Overview of operation
// - Requests run sequences loaded at initialisation
// - Engines write registers without processor help
// - Enable and disable each channel individually
// - Eleven engines: ten slice, one core
// - One slice per path, two observation
// - Slice engines run concurrently
// - Two observation paths, each shared pairwise
// - Observation paths also carry transmit loopback
// - Slice engine reaches only own sub-map
// - Core engine reaches all, runs pin sequences
// - Power-up default is software-command mode
// - Channels stay enabled until next mask
// - Receive mask selections as listed
// - Transmit mask selections as listed
`ifndef CHAN_SEQ_REGS_SVH
`define CHAN_SEQ_REGS_SVH

// Receive mask bit positions
`define RXM_RX1        0
`define RXM_RX4        3
`define RXM_OBSERVATION_INPUT_1       4
`define RXM_ORX4       7
`define RXM_LB_A       8
`define RXM_LB_B       9
`define RXM_WIDTH      10
// Transmit mask: bits 0..3 are transmitters, all-set is every transmitter
`define TXM_WIDTH      4
`define TXM_ALL        4'hF
// Engine layout: 0..3 tx, 4..7 rx, 8..9 observation paths, 10 core
`define N_SLICE        10
`define ENG_CORE       10
`define N_ENGINES      11
// Sequence store: 16 words per engine per direction
`define SEQ_STEPS      16
`define SEQ_AW         4
`define MAP_AW         12
`define SUBMAP_AW      3
// Reset values
`define RST_MODE_PIN   1'b0
`define RST_MASK       16'h0000

`endif

//--- rtl/chan_seq_pkg.sv
/*
 * Types shared by the sequencing engines.
 * Assumes the constants header sits alongside.
 */
`include "chan_seq_regs.svh"

package chan_seq_pkg;
    // Engine state
    typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_DONE} eng_state_t;
    // One sequence word: end flag, value, sub-map, in-map address
    typedef struct packed {
        logic                  last;
        logic [7:0]            wdata;
        logic [`SUBMAP_AW-1:0] submap;
        logic [`MAP_AW-1:0]    addr;
    } seq_word_t;
endpackage : chan_seq_pkg

//--- rtl/seq_engine.sv
/*
 * One sequencing engine: walks a loaded sequence and issues register writes.
 * Assumes the store is loaded before any start and that a write is taken
 * every cycle wr_o is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"

module seq_engine
    import chan_seq_pkg::*;
#(
    parameter logic [`SUBMAP_AW-1:0] OWN_MAP = '0,   // Permitted sub-map
    parameter bit                    ANY_MAP = 1'b0  // Core engine reaches all
)(
    input  wire logic                   mclk_i,      // Clock
    input  wire logic                   sys_rst_i,   // Async reset
    input  wire logic                   load_we_i,   // Store write
    input  wire logic                   load_dir_i,  // 1 enable seq, 0 disable
    input  wire logic [`SEQ_AW-1:0]     load_idx_i,  // Store index
    input  wire chan_seq_pkg::seq_word_t load_word_i, // Store data
    input  wire logic                   start_i,     // Run pulse
    input  wire logic                   dir_i,       // Direction to run
    output logic                        busy_o,      // Sequence in progress
    output logic                        done_o,      // Finish pulse
    output logic                        wr_o,        // Register write strobe
    output chan_seq_pkg::seq_word_t      wr_word_o,   // Write contents
    output logic                        viol_o       // Blocked foreign write
);
    import chan_seq_pkg::*;

    // Store for both directions, array kept local
    seq_word_t store_q [2][`SEQ_STEPS];
    eng_state_t st_q, st_d;
    logic [`SEQ_AW-1:0] pc_q, pc_d;
    logic dir_q, dir_d;
    seq_word_t cur;
    logic allowed;

    always_ff @(posedge mclk_i)
    begin
        if (load_we_i)
        begin
            store_q[load_dir_i][load_idx_i] <= load_word_i;
        end
    end

    assign cur = store_q[dir_q][pc_q];
    assign allowed = ANY_MAP || (cur.submap == OWN_MAP);

    // Next state of the walker
    always_comb
    begin
        st_d  = st_q;
        pc_d  = pc_q;
        dir_d = dir_q;
        unique case (st_q)
            ENG_IDLE:
            begin
                if (start_i)
                begin
                    st_d  = ENG_RUN;
                    pc_d  = '0;
                    dir_d = dir_i;
                end
            end
            ENG_RUN:
            begin
                pc_d = pc_q + 1'b1;
                if (cur.last || pc_q == `SEQ_AW'(`SEQ_STEPS - 1))
                begin
                    st_d = ENG_DONE;
                end
            end
            ENG_DONE:
            begin
                st_d = ENG_IDLE;
            end
        endcase
    end

    // Registered outputs
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_q      <= ENG_IDLE;
            pc_q      <= '0;
            dir_q     <= 1'b0;
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            wr_o      <= 1'b0;
            wr_word_o <= '0;
            viol_o    <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            pc_q      <= pc_d;
            dir_q     <= dir_d;
            busy_o    <= (st_d != ENG_IDLE);
            done_o    <= (st_q == ENG_RUN) && (st_d == ENG_DONE);
            wr_o      <= (st_q == ENG_RUN) && allowed;
            wr_word_o <= cur;
            viol_o    <= (st_q == ENG_RUN) && !allowed;
        end
    end
endmodule : seq_engine

`default_nettype wire

//--- rtl/chan_seq_ctrl.sv
/*
 * Channel enable control: ten slice engines plus a core engine turn
 * signal chains on and off from two channel masks or from enable pins.
 * Assumes the host loads matching sequences before the first request,
 * and that pin inputs are asynchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"

module chan_seq_ctrl
    import chan_seq_pkg::*;
(
    input  wire logic                    mclk_i,            // 200 MHz clock
    input  wire logic                    sys_rst_i,         // Async reset, high
    input  wire logic                    pin_mode_i,        // 1 pin control, 0 software
    input  wire logic [`RXM_WIDTH-1:0]   receive_channel_mask_i,  // Rx mask
    input  wire logic [`TXM_WIDTH-1:0]   transmit_channel_mask_i, // Tx mask
    input  wire logic                    mask_wr_i,         // Mask request pulse
    input  wire logic [3:0]              rx_en_pin_i,       // Receive enable pins
    input  wire logic [3:0]              tx_en_pin_i,       // Transmit enable pins
    input  wire logic [3:0]              orx_en_pin_i,      // Observation pins
    input  wire logic                    gpio_trig_i,       // Core trigger pin
    input  wire logic                    load_we_i,         // Sequence load strobe
    input  wire logic [3:0]              load_eng_i,        // Engine to load
    input  wire logic                    load_dir_i,        // Enable or disable seq
    input  wire logic [`SEQ_AW-1:0]      load_idx_i,        // Step index
    input  wire chan_seq_pkg::seq_word_t  load_word_i,       // Step contents
    output logic [3:0]                   tx_on_o,           // Transmit chains on
    output logic [3:0]                   rx_on_o,           // Receive chains on
    output logic [3:0]                   orx_on_o,          // Observation inputs on
    output logic [1:0]                   lb_on_o,           // Loopback on per path
    output logic [`N_ENGINES-1:0]        busy_o,            // Engine busy flags
    output logic                         mode_pin_o,        // Active control mode
    output logic                         reg_wr_o,          // Register write strobe
    output chan_seq_pkg::seq_word_t       reg_word_o,        // Register write word
    output logic                         viol_o             // Confinement trip seen
);
    import chan_seq_pkg::*;

    // Pin synchronisers, two stages each; stage one read only by stage two
    logic [12:0] pin_s1_q, pin_s2_q;
    logic        gpio_s3_q;  // Trigger history, idles low like the pin
    logic [12:0] pin_raw;
    assign pin_raw = {gpio_trig_i, orx_en_pin_i, rx_en_pin_i, tx_en_pin_i};

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            gpio_s3_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            gpio_s3_q <= pin_s2_q[12];
        end
    end

    // Wanted state per channel, kept until changed
    logic [3:0] want_tx_q, want_tx_d, want_rx_q, want_rx_d;
    logic [3:0] want_orx_q, want_orx_d;
    logic [1:0] want_lb_q, want_lb_d;
    logic       mode_q, mode_d;

    // Request capture, in software mode from masks, else from pins
    always_comb
    begin
        want_tx_d  = want_tx_q;
        want_rx_d  = want_rx_q;
        want_orx_d = want_orx_q;
        want_lb_d  = want_lb_q;
        mode_d     = pin_mode_i;
        if (!mode_q && mask_wr_i)
        begin
            want_rx_d  = receive_channel_mask_i[`RXM_RX4:`RXM_RX1];
            want_orx_d = receive_channel_mask_i[`RXM_ORX4:`RXM_OBSERVATION_INPUT_1];
            want_lb_d  = receive_channel_mask_i[`RXM_LB_B:`RXM_LB_A];
            // transmit mask decode, all-set covers every transmitter
            want_tx_d  = transmit_channel_mask_i & `TXM_ALL;
        end
        else if (mode_q)
        begin
            want_tx_d  = pin_s2_q[3:0];
            want_rx_d  = pin_s2_q[7:4];
            want_orx_d = pin_s2_q[11:8];
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            want_tx_q  <= '0;
            want_rx_q  <= '0;
            want_orx_q <= '0;
            want_lb_q  <= '0;
            mode_q     <= `RST_MODE_PIN;
        end
        else
        begin
            want_tx_q  <= want_tx_d;
            want_rx_q  <= want_rx_d;
            want_orx_q <= want_orx_d;
            want_lb_q  <= want_lb_d;
            mode_q     <= mode_d;
        end
    end

    // Per slice wanted level: tx 0..3, rx 4..7, observation paths 8..9.
    // each observation path serves an input pair
    logic [`N_SLICE-1:0] want_s;
    assign want_s = {(|want_orx_q[3:2]) | want_lb_q[1],
                     (|want_orx_q[1:0]) | want_lb_q[0],
                     want_rx_q, want_tx_q};

    // Per engine start, direction, busy and write signals
    logic [`N_ENGINES-1:0] start, dir, busy, wr, viol;
    seq_word_t             word [`N_ENGINES];
    logic [`N_SLICE-1:0]   on_q, on_d;
    logic                  gpio_rise;
    assign gpio_rise = pin_s2_q[12] & ~gpio_s3_q;

    // eleven engines; one per slice path plus the core; all run in parallel
    genvar g;
    generate
        for (g = 0; g < `N_ENGINES; g++)
        begin : g_eng
            if (g < `N_SLICE)
            begin : g_slice
                assign start[g] = !busy[g] && (want_s[g] != on_q[g]);
                assign dir[g]   = want_s[g];
            end
            else
            begin : g_core
                assign start[g] = !busy[g] && gpio_rise;
                assign dir[g]   = 1'b1;
            end
            seq_engine #(
                .OWN_MAP (`SUBMAP_AW'(g < 4 ? 0 : (g < 8 ? 1 : 2))),
                .ANY_MAP (g == `ENG_CORE)
            ) u_eng (
                .mclk_i      (mclk_i),
                .sys_rst_i   (sys_rst_i),
                .load_we_i   (load_we_i && (load_eng_i == 4'(g))),
                .load_dir_i  (load_dir_i),
                .load_idx_i  (load_idx_i),
                .load_word_i (load_word_i),
                .start_i     (start[g]),
                .dir_i       (dir[g]),
                .busy_o      (busy[g]),
                .done_o      (),
                .wr_o        (wr[g]),
                .wr_word_o   (word[g]),
                .viol_o      (viol[g])
            );
        end
    endgenerate

    // Chain state follows each started sequence; outputs lag one cycle
    always_comb
    begin
        on_d = on_q;
        for (int i = 0; i < `N_SLICE; i++)
        begin
            if (start[i])
            begin
                on_d[i] = dir[i];
            end
        end
    end

    // Lowest-numbered writing engine wins the shared write port; the
    // engines started by one request collide and losing writes is logged as a limitation.
    seq_word_t pick;
    logic      any_wr;
    always_comb
    begin
        pick   = '0;
        any_wr = 1'b0;
        for (int i = `N_ENGINES - 1; i >= 0; i--)
        begin
            if (wr[i])
            begin
                pick   = word[i];
                any_wr = 1'b1;
            end
        end
    end

    // Output registers
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            on_q       <= '0;
            tx_on_o    <= '0;
            rx_on_o    <= '0;
            orx_on_o   <= '0;
            lb_on_o    <= '0;
            busy_o     <= '0;
            mode_pin_o <= 1'b0;
            reg_wr_o   <= 1'b0;
            reg_word_o <= '0;
            viol_o     <= 1'b0;
        end
        else
        begin
            on_q       <= on_d;
            tx_on_o    <= on_q[3:0];
            rx_on_o    <= on_q[7:4];
            orx_on_o   <= want_orx_q & {{2{on_q[9]}}, {2{on_q[8]}}};
            lb_on_o    <= want_lb_q & on_q[9:8];
            busy_o     <= busy;
            mode_pin_o <= mode_q;
            reg_wr_o   <= any_wr;
            reg_word_o <= pick;
            viol_o     <= viol_o | (|viol);
        end
    end
endmodule : chan_seq_ctrl

`default_nettype wire

//--- tb/chan_seq_properties.sv
/* Checker for channel levels, busy flags and register writes.
   Sees only the control block's ports; the bind sits at the foot. */
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"

module chan_seq_checker
(
    input wire logic                  mclk_i,                  // Clock
    input wire logic                  sys_rst_i,               // Reset
    input wire logic                  pin_mode_i,              // Mode request
    input wire logic [`RXM_WIDTH-1:0] receive_channel_mask_i,  // Rx mask
    input wire logic [`TXM_WIDTH-1:0] transmit_channel_mask_i, // Tx mask
    input wire logic                  mask_wr_i,               // Request
    input wire logic [3:0]            tx_en_pin_i,             // Tx pins
    input wire logic                  gpio_trig_i,             // Core trigger
    input wire logic [3:0]            tx_on_o,                 // Tx on
    input wire logic [3:0]            rx_on_o,                 // Rx on
    input wire logic [3:0]            orx_on_o,                // Obs on
    input wire logic [1:0]            lb_on_o,                 // Loopback on
    input wire logic [`N_ENGINES-1:0] busy_o,                  // Busy flags
    input wire logic                  mode_pin_o,              // Mode
    input wire logic                  reg_wr_o,                // Write strobe
    input wire logic                  viol_o                   // Trip flag
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Lone request in software mode; busy engines would delay it
    sequence sw_take;
        mask_wr_i && !pin_mode_i && !mode_pin_o && busy_o == '0 && !$past(mask_wr_i)
            ##1 !mask_wr_i;
    endsequence

    a_reset_sw_mode:
        assert property ($fell(sys_rst_i) |-> !mode_pin_o && busy_o == '0)
        else $error("mode or busy set after reset");
    a_tx_follow:
        assert property (sw_take |-> ##[1:2] tx_on_o == transmit_channel_mask_i)
        else $error("transmit levels differ from mask");
    a_rx_follow:
        assert property (sw_take |-> ##[1:2]
            {lb_on_o, orx_on_o, rx_on_o} == receive_channel_mask_i)
        else $error("receive levels differ from mask");
    // transmit levels move only with a sequence
    a_tx_hold:
        assert property ($changed(tx_on_o) |-> busy_o[3:0] != '0)
        else $error("transmit level moved with no engine busy");
    a_busy_bound:
        assert property ($rose(busy_o[0]) |-> ##[1:60] !busy_o[0])
        else $error("engine stuck busy");
    a_write_in_run:
        assert property (reg_wr_o |-> $past(busy_o) != '0 || $past(busy_o, 2) != '0
            || $past(busy_o, 3) != '0)
        else $error("write with no engine running");
    a_viol_sticky:
        assert property (viol_o |=> viol_o)
        else $error("trip flag dropped");
    a_core_start:
        assert property ($rose(gpio_trig_i) |-> ##[2:8] busy_o[`ENG_CORE])
        else $error("core engine not started");
    a_pin_tx:
        assert property (mode_pin_o && pin_mode_i && $rose(tx_en_pin_i[1])
            |-> ##[2:12] tx_on_o[1])
        else $error("pin did not enable transmitter");

    c_sw_take: cover property (sw_take);
    c_both_paths: cover property (busy_o[9:8] == 2'b11);
    c_trip: cover property ($rose(viol_o));
endmodule : chan_seq_checker

bind chan_seq_ctrl chan_seq_checker chan_seq_checker_i (.mclk_i, .sys_rst_i, .pin_mode_i,
    .receive_channel_mask_i, .transmit_channel_mask_i, .mask_wr_i, .tx_en_pin_i,
    .gpio_trig_i, .tx_on_o, .rx_on_o, .orx_on_o, .lb_on_o, .busy_o, .mode_pin_o,
    .reg_wr_o, .viol_o);
`default_nettype wire

//--- tb/host_model.sv
/* Host model: loads sequence images and issues channel mask requests.
   Assumes the control block samples on the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"

module host_model
(
    input  wire logic                   mclk_i,      // Clock
    output logic [`RXM_WIDTH-1:0]       rx_mask_o,   // Receive mask
    output logic [`TXM_WIDTH-1:0]       tx_mask_o,   // Transmit mask
    output logic                        mask_wr_o,   // Request pulse
    output logic                        load_we_o,   // Store write
    output logic [3:0]                  load_eng_o,  // Engine loaded
    output logic                        load_dir_o,  // Sequence direction
    output logic [`SEQ_AW-1:0]          load_idx_o,  // Step index
    output chan_seq_pkg::seq_word_t     load_word_o  // Step word
);
    import chan_seq_pkg::*;

    initial
    begin
        {rx_mask_o, tx_mask_o, mask_wr_o, load_we_o} = '0;
        {load_eng_o, load_dir_o, load_idx_o, load_word_o} = '0;
    end

    // image matching engine map; tx_map lets a test misroute tx
    task automatic load_image(input logic [2:0] tx_map);
        for (int e = 0; e < `N_ENGINES; e++)
            for (int d = 0; d < 2; d++)
            begin
                @(negedge mclk_i);
                load_we_o   <= 1'b1;
                load_eng_o  <= 4'(e);
                load_dir_o  <= d[0];
                load_word_o <= '{1'b1, 8'(e), e < 4 ? tx_map : e < 8 ? 3'h1 :
                                 e < 10 ? 3'h2 : 3'h5, 12'(e)};
            end
        @(negedge mclk_i);
        load_we_o <= 1'b0;
    endtask : load_image

    // masks arrive as ORed selections; held until the next request
    task automatic request(input logic [9:0] rx, input logic [3:0] tx);
        @(negedge mclk_i);
        rx_mask_o <= rx;
        tx_mask_o <= tx;
        mask_wr_o <= 1'b1;
    endtask : request

    task automatic idle;
        @(negedge mclk_i);
        mask_wr_o <= 1'b0;
    endtask : idle
endmodule : host_model
`default_nettype wire

//--- tb/chan_seq_ctrl_tb.sv
/* Testbench for the channel enable block, host model at the far side.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
`include "chan_seq_regs.svh"

module chan_seq_ctrl_tb;
    import chan_seq_pkg::*;
    logic mclk_i, sys_rst_i, pin_mode_i, gpio, mode_pin, reg_wr, viol, mwr, lwe, ldir;
    logic [3:0]  rx_pin, tx_pin, tx_on, rx_on, orx_on, tm, leng, lidx;
    logic [1:0]  lb_on;
    logic [9:0]  rm;
    logic [10:0] busy;
    seq_word_t   lword, rword, last_word;
    logic [13:0] notes[$], cur, nxt;
    int errors, comparisons, idle_n, writes;

    host_model host_model_i (.mclk_i, .rx_mask_o(rm), .tx_mask_o(tm), .mask_wr_o(mwr),
        .load_we_o(lwe), .load_eng_o(leng), .load_dir_o(ldir), .load_idx_o(lidx),
        .load_word_o(lword));
    chan_seq_ctrl chan_seq_ctrl_i (.mclk_i, .sys_rst_i, .pin_mode_i,
        .receive_channel_mask_i(rm), .transmit_channel_mask_i(tm), .mask_wr_i(mwr),
        .rx_en_pin_i(rx_pin), .tx_en_pin_i(tx_pin), .orx_en_pin_i(4'h0),
        .gpio_trig_i(gpio), .load_we_i(lwe), .load_eng_i(leng), .load_dir_i(ldir),
        .load_idx_i(lidx), .load_word_i(lword), .tx_on_o(tx_on), .rx_on_o(rx_on),
        .orx_on_o(orx_on), .lb_on_o(lb_on), .busy_o(busy), .mode_pin_o(mode_pin),
        .reg_wr_o(reg_wr), .reg_word_o(rword), .viol_o(viol));

    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [13:0] e, input logic [13:0] s);
        comparisons++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask : check

    // Oldest note is compared once every engine has been idle three cycles
    always @(negedge mclk_i)
    begin
        idle_n = (busy == '0) ? idle_n + 1 : 0;
        writes += int'(reg_wr === 1'b1);
        if (reg_wr === 1'b1)
            last_word = rword;
        if (idle_n >= 3 && notes.size() > 0)
            check("on_levels", notes.pop_front(), {tx_on, lb_on, orx_on, rx_on});
    end

    task automatic settle(input logic [13:0] e);
        // Give the engines time to go busy before the note may be taken
        repeat (6) @(negedge mclk_i);
        notes.push_back(e);
        for (int i = 0; i < 200 && notes.size() > 0; i++)
            @(negedge mclk_i);
        cur = e;
    endtask : settle

    task automatic complete_run;
        errors += notes.size();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        #100us;
        errors++;
        complete_run();
    end

    initial
    begin
        logic [3:0] tx_sel[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, `TXM_ALL};
        {sys_rst_i, pin_mode_i, gpio, rx_pin, tx_pin} = {1'b1, 10'h000};
        void'($urandom(14));
        repeat (2) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        @(negedge mclk_i);
        check("reset_levels", 14'h0, {tx_on, lb_on, orx_on, rx_on});
        check("reset_flags", 14'h0, {2'b0, mode_pin, busy});
        host_model_i.load_image(3'h0);
        // Every receive and transmit selection, both directions
        for (int k = 0; k < 11; k++)
        begin
            nxt = {tx_sel[k % 6], 10'(k == 0 ? 0 : 1 << (k - 1))};
            host_model_i.request(nxt[9:0], nxt[13:10]);
            host_model_i.idle();
            settle(nxt);
        end
        // Random masks switch several engines at once
        repeat (6)
        begin
            nxt = 14'($urandom) ^ ((14'($urandom) == cur) ? 14'h1 : 14'h0);
            nxt = (nxt == cur) ? ~cur : nxt;
            host_model_i.request(nxt[9:0], nxt[13:10]);
            host_model_i.idle();
            settle(nxt);
        end
        // Back to back: busy engines finish, then settle on the latest
        host_model_i.request(~cur[9:0], ~cur[13:10]);
        nxt = {cur[13:10] ^ 4'h5, 2'b00, cur[7:0] ^ 8'h3C};
        host_model_i.request(nxt[9:0], nxt[13:10]);
        host_model_i.idle();
        settle(nxt);
        // Pin mode: pins low turn chains off, masks are refused
        pin_mode_i = 1'b1;
        settle(14'h0);
        host_model_i.request(10'h3FF, `TXM_ALL);
        host_model_i.idle();
        repeat (20) @(negedge mclk_i);
        check("refused", 14'h0, {tx_on, lb_on, orx_on, rx_on});
        check("mode_pin", 14'h1, {13'h0, mode_pin});
        // several chains switched together through the pins
        tx_pin = 4'($urandom) | 4'h2;
        rx_pin = 4'($urandom);
        settle({tx_pin, 6'h00, rx_pin});
        {tx_pin, rx_pin} = 8'h00;
        settle(14'h0);
        pin_mode_i = 1'b0;
        repeat (10) @(negedge mclk_i);
        // Core engine from the trigger pin
        gpio = 1'b1;
        repeat (12) @(negedge mclk_i);
        gpio = 1'b0;
        check("core_word", {6'h05, 8'h0A}, {3'h0, last_word.submap, last_word.wdata});
        check("no_trip", 14'h0, {13'h0, viol});
        // Misrouted transmit image trips the confinement flag
        host_model_i.load_image(3'h1);
        host_model_i.request(10'h000, 4'h1);
        host_model_i.idle();
        settle(14'h1 << 10);
        check("trip", 14'h1, {13'h0, viol});
        check("writes", 14'h1, {13'h0, writes != 0});
        complete_run();
    end
endmodule : chan_seq_ctrl_tb
`default_nettype wire
